//--- rtl/gpiec_pkg.sv
// Package of register map, field layout and event codes for the input interrupt and event block.
package gpiec_pkg;
   localparam int unsigned NUM_INPUTS     = 11;
   localparam int unsigned LO_INPUTS      = 6;
   localparam int unsigned HI_INPUTS      = 5;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 8;
   // Register offsets.
   localparam logic [7:0] ADDR_STATUS       = 8'h01;
   localparam logic [7:0] ADDR_PENDING_LO   = 8'h13;
   localparam logic [7:0] ADDR_PENDING_HI   = 8'h14;
   localparam logic [7:0] ADDR_INPUT_LVL_LO = 8'h15;
   localparam logic [7:0] ADDR_INPUT_LVL_HI = 8'h16;
   localparam logic [7:0] ADDR_LEVEL_SEL_LO = 8'h1b;
   localparam logic [7:0] ADDR_LEVEL_SEL_HI = 8'h1c;
   localparam logic [7:0] ADDR_EVENT_EN_LO  = 8'h1d;
   localparam logic [7:0] ADDR_EVENT_EN_HI  = 8'h1e;
   localparam logic [7:0] ADDR_IRQ_EN_LO    = 8'h1f;
   localparam logic [7:0] ADDR_IRQ_EN_HI    = 8'h20;
   localparam logic [7:0] ADDR_INT_CLEAR    = 8'h30;
   localparam logic [7:0] ADDR_INT_ENABLE   = 8'h31;
   // Status register bit positions.
   localparam int unsigned STAT_EVENT_BIT   = 0;
   localparam int unsigned STAT_INPUT_BIT   = 1;
   localparam int unsigned STAT_OVFL_BIT    = 2;
   // Writable masks: bit 5 of the low group only exists on the eleven-input variant.
   localparam logic [7:0] MASK_LO_FULL     = 8'h3f;
   localparam logic [7:0] MASK_LO_REDUCED  = 8'h1f;
   localparam logic [7:0] MASK_HI          = 8'h1f;
   localparam logic [7:0] MASK_STATUS      = 8'h07;
   localparam logic [7:0] RESET_VALUE      = 8'h00;
   // Event code layout: bit 7 is the state, low bits the event number.
   localparam logic [6:0] EVENT_CODE_BASE  = 7'h25;
   localparam int unsigned EVENT_STATE_BIT = 7;
endpackage : gpiec_pkg

//--- rtl/gpiec_top.sv
// Level select, event logging and interrupt enable logic for the general-purpose inputs.
//
// Overview of operation
// - Level bit 0: pending while row low.
// - Level bit 1: pending while row high.
// - High level register: inputs 7-11, rows 6-10.
// - Low level register: inputs 1-6, rows 0-5.
// - Event enable 0: no event entries.
// - Event enable 1: activity logged as events.
// - Event enable bit layout, reserved tops.
// - Event-mode activity raises event interrupt status.
// - Event-mode inputs never raise input summary.
// - Logged input events are ordinary events.
// - Interrupt enable 0: pending flag ignored.
// - Enable 1: pending plus condition sets summary.
// - Low interrupt enable: inputs 1-6, bits 0-5.
// - High interrupt enable: inputs 7-11, bits 0-4.
// - Input 6 controls inactive unless eleven-input variant.
`timescale 1ns/1ns
`default_nettype none
module gpiec_top #(
   parameter bit HAS_INPUT6 = 1'b0
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset,
   // Input pins, row lines 0 to 10.
   input  wire logic [10:0] row_line,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   // Event entries toward the event store.
   output logic             event_valid,
   output logic      [7:0]  event_code,
   // Interrupt.
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [10:0] sync1;
      logic [10:0] sync2;
      logic [10:0] prev_active;
      logic [10:0] level_sel;
      logic [10:0] event_en;
      logic [10:0] irq_en;
      logic [10:0] pending;
      logic [2:0]  status;
      logic [2:0]  int_en;
      logic [7:0]  rdata;
      logic        event_valid;
      logic [7:0]  event_code;
      logic        irq;
   } gpiec_state_s;

   gpiec_state_s state_ff;
   gpiec_state_s nxt_state;

   // Writable low-group mask depends on the variant.
   localparam logic [7:0] LO_MASK = HAS_INPUT6 ? gpiec_pkg::MASK_LO_FULL
                                               : gpiec_pkg::MASK_LO_REDUCED;
   localparam logic [10:0] ALL_MASK = {gpiec_pkg::MASK_HI[4:0], LO_MASK[5:0]};

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [10:0] active;
      logic [10:0] change;
      logic [10:0] set_pending;
      logic [10:0] clr_pending;
      logic        summary;
      logic        found;
      logic [3:0]  idx;
      logic [2:0]  set_status;
      logic [2:0]  clr_status;
      logic [7:0]  rd;
      nxt_state = state_ff;
      active = '0;
      change = '0;
      set_pending = '0;
      clr_pending = '0;
      summary = 1'b0;
      found = 1'b0;
      idx = 4'h0;
      set_status = 3'h0;
      clr_status = 3'h0;
      rd = 8'h00;

      // Two-flop synchroniser on the row pins.
      nxt_state.sync1 = row_line;
      nxt_state.sync2 = state_ff.sync1;

      // level condition: active when pin equals level bit.
      // input n watches row line n-1.
      active = ~(state_ff.sync2 ^ state_ff.level_sel) & ALL_MASK;
      change = (active ^ state_ff.prev_active) & ALL_MASK;
      nxt_state.prev_active = active;

      // pending flags only for inputs outside event mode.
      set_pending = active & ~state_ff.event_en;

      // lowest-numbered changing event-mode input is logged.
      nxt_state.event_valid = 1'b0;
      for (int i = 0; i < 11; i++) begin
         if (!found && change[i] && state_ff.event_en[i]) begin
            found = 1'b1;
            idx = 4'(i);
         end
      end
      if (found) begin
         // code shares the ordinary event format.
         nxt_state.event_valid = 1'b1;
         nxt_state.event_code = {active[idx], gpiec_pkg::EVENT_CODE_BASE + 7'(idx)};
         set_status[gpiec_pkg::STAT_EVENT_BIT] = 1'b1;
      end
      // Several simultaneous changes lose all but one; flag the loss.
      if ((change & state_ff.event_en) != (11'h001 << idx) && found) begin
         set_status[gpiec_pkg::STAT_OVFL_BIT] = 1'b1;
      end

      // summary of enabled pending non-event inputs.
      summary = |(state_ff.pending & active & state_ff.irq_en & ~state_ff.event_en);
      if (summary) begin
         set_status[gpiec_pkg::STAT_INPUT_BIT] = 1'b1;
      end

      // Register writes.
      if (reg_write) begin
         case (reg_addr)
            gpiec_pkg::ADDR_LEVEL_SEL_LO: nxt_state.level_sel[5:0] = reg_wdata[5:0] & LO_MASK[5:0];
            gpiec_pkg::ADDR_LEVEL_SEL_HI: nxt_state.level_sel[10:6] = reg_wdata[4:0];
            gpiec_pkg::ADDR_EVENT_EN_LO:  nxt_state.event_en[5:0] = reg_wdata[5:0] & LO_MASK[5:0];
            gpiec_pkg::ADDR_EVENT_EN_HI:  nxt_state.event_en[10:6] = reg_wdata[4:0];
            gpiec_pkg::ADDR_IRQ_EN_LO:    nxt_state.irq_en[5:0] = reg_wdata[5:0] & LO_MASK[5:0];
            gpiec_pkg::ADDR_IRQ_EN_HI:    nxt_state.irq_en[10:6] = reg_wdata[4:0];
            gpiec_pkg::ADDR_INT_CLEAR:    clr_status = reg_wdata[2:0];
            gpiec_pkg::ADDR_INT_ENABLE:   nxt_state.int_en = reg_wdata[2:0];
            default: begin
            end
         endcase
      end

      // Reads of the pending registers clear the flags they return.
      if (reg_read && reg_addr == gpiec_pkg::ADDR_PENDING_LO) begin
         clr_pending[5:0] = state_ff.pending[5:0];
      end
      if (reg_read && reg_addr == gpiec_pkg::ADDR_PENDING_HI) begin
         clr_pending[10:6] = state_ff.pending[10:6];
      end
      // Set wins over clear.
      nxt_state.pending = ((state_ff.pending & ~clr_pending) | set_pending) & ALL_MASK
                          & ~state_ff.event_en;
      nxt_state.status = (state_ff.status & ~clr_status) | set_status;

      // Register reads; unmapped addresses read zero.
      if (reg_read) begin
         case (reg_addr)
            gpiec_pkg::ADDR_STATUS:       rd = {5'h00, state_ff.status};
            gpiec_pkg::ADDR_PENDING_LO:   rd = {2'h0, state_ff.pending[5:0]};
            gpiec_pkg::ADDR_PENDING_HI:   rd = {3'h0, state_ff.pending[10:6]};
            gpiec_pkg::ADDR_INPUT_LVL_LO: rd = {2'h0, state_ff.sync2[5:0] & LO_MASK[5:0]};
            gpiec_pkg::ADDR_INPUT_LVL_HI: rd = {3'h0, state_ff.sync2[10:6]};
            gpiec_pkg::ADDR_LEVEL_SEL_LO: rd = {2'h0, state_ff.level_sel[5:0]};
            gpiec_pkg::ADDR_LEVEL_SEL_HI: rd = {3'h0, state_ff.level_sel[10:6]};
            gpiec_pkg::ADDR_EVENT_EN_LO:  rd = {2'h0, state_ff.event_en[5:0]};
            gpiec_pkg::ADDR_EVENT_EN_HI:  rd = {3'h0, state_ff.event_en[10:6]};
            gpiec_pkg::ADDR_IRQ_EN_LO:    rd = {2'h0, state_ff.irq_en[5:0]};
            gpiec_pkg::ADDR_IRQ_EN_HI:    rd = {3'h0, state_ff.irq_en[10:6]};
            gpiec_pkg::ADDR_INT_ENABLE:   rd = {5'h00, state_ff.int_en};
            default:                      rd = 8'h00;
         endcase
      end
      nxt_state.rdata = rd;

      nxt_state.irq = |(nxt_state.status & nxt_state.int_en);
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata   = state_ff.rdata;
   assign event_valid = state_ff.event_valid;
   assign event_code  = state_ff.event_code;
   assign irq         = state_ff.irq;

endmodule // gpiec_top
`default_nettype wire

//--- sim/gpiec_chk.sv
// Checker of the register port and event outputs.
`timescale 1ns/1ns
`default_nettype none
module gpiec_chk #(parameter bit HAS_INPUT6 = 1'b0) (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       reset,
   // Register port and outputs.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       event_valid,
   input wire logic [7:0] event_code
);
   localparam logic [7:0] LO_M = HAS_INPUT6 ? 8'h3f : 8'h1f;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_resv_lo: assert property ($past(reg_read) && $past(reg_addr) inside
      {8'h13, 8'h15, 8'h1b, 8'h1d, 8'h1f} |-> (reg_rdata & ~LO_M) == 8'h00)
      else $error("low group reserved bit set");
   a_resv_hi: assert property ($past(reg_read) && $past(reg_addr) inside
      {8'h14, 8'h16, 8'h1c, 8'h1e, 8'h20} |-> reg_rdata[7:5] == 3'h0)
      else $error("high group reserved bit set");
   a_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) > 8'h31
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_status_resv: assert property ($past(reg_read) && $past(reg_addr) == 8'h01
      |-> reg_rdata[7:3] == 5'h00) else $error("status reserved bit set");
   a_wb_hi: assert property (reg_write && reg_addr inside {8'h1c, 8'h1e, 8'h20}
      ##2 reg_read && reg_addr == $past(reg_addr, 2)
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1f)) else $error("high readback");
   a_wb_lo: assert property (reg_write && reg_addr inside {8'h1b, 8'h1d, 8'h1f}
      ##2 reg_read && reg_addr == $past(reg_addr, 2)
      |=> reg_rdata == ($past(reg_wdata, 3) & LO_M)) else $error("low readback");
   a_event_code: assert property (event_valid |-> event_code[6:0] >= 7'h25
      && event_code[6:0] <= 7'h2f) else $error("event code out of range");
endmodule // gpiec_chk
`default_nettype wire

//--- sim/gpiec_host.sv
// Host model that programs the registers over the plain port.
`timescale 1ns/1ns
`default_nettype none
module gpiec_host (
   // Clock.
   input  wire logic       clk,
   // Register port.
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   // Read data are taken at the edge that ends their only cycle.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
endmodule // gpiec_host
`default_nettype wire

//--- sim/gpiec_top_tb.sv
// Testbench of the input level, event and interrupt block.
`timescale 1ns/1ns
`default_nettype none
module gpiec_top_tb;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [10:0] row_line = 11'h000;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, event_code, d;
   logic        reg_write, reg_read, event_valid, irq;
   logic [7:0]  ev_cnt = 8'h00;
   logic [7:0]  last_code = 8'h00;
   int          fails = 0;
   int          comparisons = 0;
   always #50 clk = ~clk;
   gpiec_top dut_u (.clk(clk), .reset(reset), .row_line(row_line), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .event_valid(event_valid), .event_code(event_code), .irq(irq));
   gpiec_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   always @(posedge clk) if (event_valid === 1'b1) begin
      ev_cnt <= ev_cnt + 8'h01;
      last_code <= event_code;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The first read drops a stale flag, the second shows the live one.
   task automatic pend(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      repeat (6) @(posedge clk);
      host_u.rd(a, d);
      host_u.rd(a, d);
      chk(d & m, e);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int a = 8'h1b; a <= 8'h20; a++) begin
         host_u.rd(8'(a), d);
         chk(d, 8'h00);
         host_u.wr(8'(a), 8'hff);
         host_u.rd(8'(a), d);
         chk(d, 8'h1f);
      end
      host_u.wr(8'h40, 8'hff);
      host_u.rd(8'h40, d);
      chk(d, 8'h00);
      host_u.wr(8'h1d, 8'h00);
      host_u.wr(8'h1e, 8'h00);
      for (int i = 0; i < 5; i++) begin
         row_line <= 11'h040 << i;
         pend(8'h14, 8'hff, 8'h01 << i);
         row_line <= 11'h001 << i;
         pend(8'h13, 8'h3f, 8'h01 << i);
      end
      host_u.wr(8'h1c, 8'h00);
      row_line <= 11'h080;
      pend(8'h14, 8'hff, 8'h1d);
      host_u.wr(8'h1f, 8'h00);
      host_u.wr(8'h20, 8'h00);
      host_u.wr(8'h31, 8'h02);
      host_u.wr(8'h30, 8'hff);
      pend(8'h01, 8'hff, 8'h00);
      host_u.wr(8'h20, 8'h01);
      pend(8'h01, 8'hff, 8'h02);
      chk({7'h00, irq}, 8'h01);
      host_u.wr(8'h1e, 8'h01);
      host_u.wr(8'h30, 8'hff);
      pend(8'h01, 8'hff, 8'h00);
      chk(ev_cnt, 8'h00);
      row_line <= 11'h0c0;
      repeat (6) @(posedge clk);
      chk(ev_cnt, 8'h01);
      chk(last_code, 8'h2b);
      row_line <= 11'h080;
      pend(8'h01, 8'hff, 8'h01);
      chk(last_code, 8'hab);
      chk({7'h00, irq}, 8'h00);
      host_u.wr(8'h31, 8'h03);
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h01);
      host_u.wr(8'h30, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run();
   end
endmodule // gpiec_top_tb
bind gpiec_top gpiec_chk #(.HAS_INPUT6(HAS_INPUT6)) chk_u (.clk(clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .event_valid(event_valid), .event_code(event_code));
`default_nettype wire
